// ===== rtl/iouerf_pkg.sv
// constants and carrier types for the unit error flag and restart block
package iouerf_pkg;
  localparam int NUNIT = 16;
  localparam logic [15:0] BASE_MASK = 16'h03ff;
  localparam logic [15:0] EXT_MASK = 16'hffff;
  localparam logic [15:0] ALL_UNITS = 16'hffff;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [2:0] IEN_RST = 3'h0;
  // register byte offsets
  localparam logic [7:0] OFS_ERR = 8'h00;
  localparam logic [7:0] OFS_RST = 8'h04;
  localparam logic [7:0] OFS_XERR = 8'h08;
  localparam logic [7:0] OFS_XRST = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_ISTS = 8'h14;
  localparam logic [7:0] OFS_ICLR = 8'h18;
  localparam logic [7:0] OFS_IEN = 8'h1c;
  // status register fields
  localparam int STAT_FAULT = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_WAIT = 2;
  // interrupt status fields
  localparam int IRQ_DUP = 0;
  localparam int IRQ_REF = 1;
  localparam int IRQ_WAIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {IOUERF_PH_IDLE, IOUERF_PH_LOW, IOUERF_PH_HIGH} iouerf_phase_t;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } iouerf_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } iouerf_axi_rsp_t;
  typedef struct packed {
    logic [15:0] num_clash;
    logic [15:0] refresh_fail;
    logic [15:0] defective;
  } iouerf_unit_in_t;
  typedef struct packed {
    logic [15:0] restart;
    logic [15:0] service_en;
    logic [15:0] unidentified;
    logic prog_run;
    logic cpu_waiting;
    logic shared_fault;
  } iouerf_unit_out_t;
endpackage

// ===== rtl/iouerf_top.sv
// unit error flags, shared fault bit and restart control with axi4-lite registers
// Functional notes
// - A duplicated unit number sets the shared fault bit and stops the program.
// - A refresh failure sets the shared fault bit, keeps running, and stops only that unit.
// - Units 0 to 9 each own an error flag raised only for the unit in error.
// - A duplicated number is shown by its unit's flag in bits 0 to 15 of the first error word.
// - Units 0 to 9 restart after an off, on, off sequence on their bit of the restart word.
// - An extended error word reports faults of units 0 to 15, one bit each.
// - An extended restart word restarts units 0 to 15 with the same pulse sequence.
// - Power-up restarts every unit just as a restart pulse does.
// - A defective unit keeps the controller waiting and shows that unit as unidentified.
// - A unit number change takes effect only at power-up or at that unit's restart.
//
// The AXI4-Lite register port and the address map were left to the implementer.
module iouerf_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register bus
  input wire iouerf_pkg::iouerf_axi_req_t axi_req,
  output iouerf_pkg::iouerf_axi_rsp_t axi_rsp,
  // unit side
  input wire iouerf_pkg::iouerf_unit_in_t unit_in,
  output iouerf_pkg::iouerf_unit_out_t unit_out,
  // interrupt
  output logic irq
);

  typedef struct packed {
    iouerf_pkg::iouerf_axi_rsp_t rsp;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [15:0] rst_word;
    logic [15:0] xrst_word;
    iouerf_pkg::iouerf_phase_t [15:0] ph_a;
    iouerf_pkg::iouerf_phase_t [15:0] ph_b;
    logic [15:0] err;
    logic [15:0] dup_eff;
    logic [2:0] ists;
    logic [2:0] ien;
    iouerf_pkg::iouerf_unit_out_t uo;
    logic irq;
    logic pwr_pend;
  } iouerf_state_t;

  iouerf_state_t q;
  iouerf_state_t next_q;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] iouerf_merge(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb,
                                               input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    return v & mask;
  endfunction

  // one step of the low, high, low watcher
  function automatic iouerf_pkg::iouerf_phase_t iouerf_step(
      input iouerf_pkg::iouerf_phase_t ph, input logic b);
    iouerf_pkg::iouerf_phase_t n;
    n = ph;
    unique case (ph)
      iouerf_pkg::IOUERF_PH_IDLE: begin
        if (!b) begin
          n = iouerf_pkg::IOUERF_PH_LOW;
        end
      end
      iouerf_pkg::IOUERF_PH_LOW: begin
        if (b) begin
          n = iouerf_pkg::IOUERF_PH_HIGH;
        end
      end
      iouerf_pkg::IOUERF_PH_HIGH: begin
        if (!b) begin
          n = iouerf_pkg::IOUERF_PH_LOW;
        end
      end
      default: begin
        n = iouerf_pkg::IOUERF_PH_IDLE;
      end
    endcase
    return n;
  endfunction

  function automatic logic iouerf_fires(input iouerf_pkg::iouerf_phase_t ph, input logic b);
    return (ph == iouerf_pkg::IOUERF_PH_HIGH) && !b;
  endfunction

  logic [15:0] rs;
  logic do_wr;
  logic wr_ok;
  logic [2:0] ev;

  always_comb begin
    next_q = q;
    rs = '0;
    ev = '0;
    do_wr = 1'b0;
    wr_ok = 1'b0;
    next_q.uo.restart = '0;
    // write address and data are taken in either order
    if (q.rsp.awready && axi_req.awvalid) begin
      next_q.aw_got = 1'b1;
      next_q.awaddr = axi_req.awaddr;
    end
    if (q.rsp.wready && axi_req.wvalid) begin
      next_q.w_got = 1'b1;
      next_q.wdata = axi_req.wdata;
      next_q.wstrb = axi_req.wstrb;
    end
    if (q.rsp.bvalid && axi_req.bready) begin
      next_q.rsp.bvalid = 1'b0;
    end
    do_wr = next_q.aw_got && next_q.w_got && !next_q.rsp.bvalid;
    if (do_wr) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.rsp.bvalid = 1'b1;
      wr_ok = 1'b1;
      unique case (next_q.awaddr)
        iouerf_pkg::OFS_RST: begin
          next_q.rst_word = iouerf_merge(q.rst_word, next_q.wdata, next_q.wstrb,
                                         iouerf_pkg::BASE_MASK);
        end
        iouerf_pkg::OFS_XRST: begin
          next_q.xrst_word = iouerf_merge(q.xrst_word, next_q.wdata, next_q.wstrb,
                                          iouerf_pkg::EXT_MASK);
        end
        iouerf_pkg::OFS_ICLR: begin
          if (next_q.wstrb[0]) begin
            next_q.ists = q.ists & ~next_q.wdata[2:0];
          end
        end
        iouerf_pkg::OFS_IEN: begin
          if (next_q.wstrb[0]) begin
            next_q.ien = next_q.wdata[2:0];
          end
        end
        // error and status words are read-only; writes are dropped with OKAY
        iouerf_pkg::OFS_ERR, iouerf_pkg::OFS_XERR, iouerf_pkg::OFS_STAT,
        iouerf_pkg::OFS_ISTS: begin
          wr_ok = 1'b1;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      next_q.rsp.bresp = wr_ok ? iouerf_pkg::RESP_OKAY : iouerf_pkg::RESP_SLVERR;
    end
    next_q.rsp.awready = !next_q.aw_got && !next_q.rsp.bvalid;
    next_q.rsp.wready = !next_q.w_got && !next_q.rsp.bvalid;
    // read channel
    if (q.rsp.rvalid && axi_req.rready) begin
      next_q.rsp.rvalid = 1'b0;
    end
    if (q.rsp.arready && axi_req.arvalid) begin
      next_q.rsp.rvalid = 1'b1;
      next_q.rsp.rresp = iouerf_pkg::RESP_OKAY;
      next_q.rsp.rdata = '0;
      unique case (axi_req.araddr)
        iouerf_pkg::OFS_ERR: begin
          next_q.rsp.rdata[15:0] = q.err;
        end
        iouerf_pkg::OFS_RST: begin
          next_q.rsp.rdata[15:0] = q.rst_word;
        end
        iouerf_pkg::OFS_XERR: begin
          next_q.rsp.rdata[15:0] = q.err;
        end
        iouerf_pkg::OFS_XRST: begin
          next_q.rsp.rdata[15:0] = q.xrst_word;
        end
        iouerf_pkg::OFS_STAT: begin
          next_q.rsp.rdata[iouerf_pkg::STAT_FAULT] = q.uo.shared_fault;
          next_q.rsp.rdata[iouerf_pkg::STAT_RUN] = q.uo.prog_run;
          next_q.rsp.rdata[iouerf_pkg::STAT_WAIT] = q.uo.cpu_waiting;
        end
        iouerf_pkg::OFS_ISTS: begin
          next_q.rsp.rdata[2:0] = q.ists;
        end
        iouerf_pkg::OFS_IEN: begin
          next_q.rsp.rdata[2:0] = q.ien;
        end
        iouerf_pkg::OFS_ICLR: begin
          next_q.rsp.rdata = '0;
        end
        default: begin
          next_q.rsp.rresp = iouerf_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_q.rsp.arready = !next_q.rsp.rvalid;
    // watchers look at the stored words, so a write lands one cycle before it counts
    for (int i = 0; i < iouerf_pkg::NUNIT; i++) begin
      next_q.ph_a[i] = iouerf_step(q.ph_a[i], q.rst_word[i]);
      next_q.ph_b[i] = iouerf_step(q.ph_b[i], q.xrst_word[i]);
      rs[i] = iouerf_fires(q.ph_a[i], q.rst_word[i])
              || iouerf_fires(q.ph_b[i], q.xrst_word[i])
              || q.pwr_pend;
    end
    next_q.pwr_pend = 1'b0;
    next_q.uo.restart = rs;
    for (int i = 0; i < iouerf_pkg::NUNIT; i++) begin
      if (rs[i]) begin
        next_q.dup_eff[i] = unit_in.num_clash[i];
        next_q.err[i] = 1'b0;
        next_q.uo.service_en[i] = 1'b1;
      end
      // a fault in the restart cycle still wins
      if (unit_in.refresh_fail[i] || next_q.dup_eff[i]) begin
        next_q.err[i] = 1'b1;
        next_q.uo.service_en[i] = 1'b0;
      end
    end
    next_q.uo.shared_fault = |next_q.err;
    next_q.uo.unidentified = unit_in.defective;
    next_q.uo.cpu_waiting = |unit_in.defective;
    // refresh faults leave the program running
    next_q.uo.prog_run = !(|next_q.dup_eff) && !next_q.uo.cpu_waiting;
    ev[iouerf_pkg::IRQ_DUP] = |(next_q.dup_eff & ~q.dup_eff);
    ev[iouerf_pkg::IRQ_REF] = |unit_in.refresh_fail;
    ev[iouerf_pkg::IRQ_WAIT] = next_q.uo.cpu_waiting && !q.uo.cpu_waiting;
    next_q.ists = next_q.ists | ev;
    next_q.irq = |(next_q.ists & next_q.ien);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.pwr_pend <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign axi_rsp = q.rsp;
  assign unit_out = q.uo;
  assign irq = q.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  chk_dup_stops_run: assert property (
    (|q.dup_eff) |-> (!q.uo.prog_run && q.uo.shared_fault))
    else $error("duplicate number did not stop the program");

  // no clash on the inputs, so no restart in that cycle can latch a duplicate
  chk_ref_one_unit: assert property (
    ((|unit_in.refresh_fail) && !(|q.dup_eff) && !(|unit_in.num_clash)
     && !(|unit_in.defective))
    |=> (((q.err & $past(unit_in.refresh_fail)) == $past(unit_in.refresh_fail))
         && ((q.uo.service_en & $past(unit_in.refresh_fail)) == 16'h0000)
         && q.uo.shared_fault && q.uo.prog_run))
    else $error("refresh fault not confined to its unit");

  chk_err_only_cause: assert property (
    (q.err & ~$past(q.err) & ~($past(unit_in.refresh_fail) | q.dup_eff)) == 16'h0000)
    else $error("error flag raised without cause");

  chk_dup_flag_bit: assert property (
    (|(q.dup_eff & ~$past(q.dup_eff))) |-> ((q.dup_eff & ~q.err) == 16'h0000))
    else $error("duplicated unit flag missing");

  chk_restart_seq: assert property (
    (q.uo.restart[2] && !$past(q.pwr_pend))
    |-> ((!$past(q.rst_word[2]) && $past(q.rst_word[2], 2))
         || (!$past(q.xrst_word[2]) && $past(q.xrst_word[2], 2))
         || ($past(q.ph_a[2]) == iouerf_pkg::IOUERF_PH_HIGH)
         || ($past(q.ph_b[2]) == iouerf_pkg::IOUERF_PH_HIGH)))
    else $error("restart without off on off");

  chk_lone_edge: assert property (
    $rose(q.xrst_word[12]) |=> !q.uo.restart[12])
    else $error("rising edge alone restarted a unit");

  chk_ext_restart: assert property (
    (q.ph_b[13] == iouerf_pkg::IOUERF_PH_HIGH && !q.xrst_word[13]) |=> q.uo.restart[13])
    else $error("extended restart pulse missed");

  chk_power_restart: assert property (
    $fell(q.pwr_pend) |-> (q.uo.restart == iouerf_pkg::ALL_UNITS))
    else $error("power-up did not restart all units");

  chk_wait_state: assert property (
    unit_in.defective[9] |=> (q.uo.cpu_waiting && q.uo.unidentified[9] && !q.uo.prog_run))
    else $error("defective unit did not hold the controller waiting");

  chk_num_latched: assert property (
    ((q.dup_eff ^ $past(q.dup_eff)) & ~q.uo.restart) == 16'h0000)
    else $error("unit number changed without restart");

  cov_sw_restart: cover property (
    !q.pwr_pend && q.uo.restart[0] && !q.uo.restart[1]);
  cov_dup_fault: cover property ($rose(q.uo.shared_fault) && !q.uo.prog_run);
  cov_ref_fault: cover property ($rose(q.uo.shared_fault) && q.uo.prog_run);
  cov_irq: cover property ($rose(q.irq));

endmodule

// ===== verif/iouerf_unit_model.sv
// behavioural model of the numbered i/o units on the far side
module iouerf_unit_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // bench commands, one bit per unit
  input wire logic [15:0] fail_cmd,
  input wire logic [15:0] clash_cmd,
  input wire logic [15:0] defect_cmd,
  // controller side
  input wire logic [15:0] service_en,
  output iouerf_pkg::iouerf_unit_in_t unit_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // an unserviced unit has no exchange left that could fail
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      unit_in <= '0;
    end else begin
      unit_in.refresh_fail <= fail_cmd & service_en;
      unit_in.num_clash <= clash_cmd;
      unit_in.defective <= defect_cmd;
    end
  end
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the unit error flag and restart block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  iouerf_pkg::iouerf_axi_req_t axi_req = '0;
  iouerf_pkg::iouerf_axi_rsp_t axi_rsp;
  iouerf_pkg::iouerf_unit_in_t unit_in;
  iouerf_pkg::iouerf_unit_out_t unit_out;
  logic irq;
  logic [15:0] fail_cmd = 16'h0000;
  logic [15:0] clash_cmd = 16'h0000;
  logic [15:0] defect_cmd = 16'h0000;
  logic [15:0] lfsr = 16'h1dc9;
  logic [31:0] rdat;
  logic [1:0] resp;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int err_m = 0;
  int rs_n[16];
  int rs_tot = 0;
  int u;
  always #2.5 mclk = ~mclk;
  iouerf_top iouerf_top_i (.mclk(mclk), .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .unit_in(unit_in), .unit_out(unit_out), .irq(irq));
  iouerf_unit_model iouerf_unit_model_i (.mclk(mclk), .rst_b(rst_b), .fail_cmd(fail_cmd),
    .clash_cmd(clash_cmd), .defect_cmd(defect_cmd), .service_en(unit_out.service_en),
    .unit_in(unit_in));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a hang counts against the run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      stop_test();
    end
  end
  always @(posedge mclk) begin
    for (int i = 0; i < 16; i++) begin
      if (unit_out.restart[i] === 1'b1) begin
        rs_n[i]++;
        rs_tot++;
      end
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (!aw_ok && axi_rsp.awready === 1'b1) begin
        aw_ok = 1;
        axi_req.awvalid <= 1'b0;
      end
      if (!w_ok && axi_rsp.wready === 1'b1) begin
        w_ok = 1;
        axi_req.wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (axi_rsp.bvalid !== 1'b1);
    // bready stays up so a following call never drives it twice in one step
    resp = axi_rsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do @(posedge mclk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    do @(posedge mclk); while (axi_rsp.rvalid !== 1'b1);
    rdat = axi_rsp.rdata;
    resp = axi_rsp.rresp;
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, rdat, e);
  endtask
  // units 10 to 15 only reach their watcher through the extended word
  task automatic restart_unit(input int n);
    logic [7:0] a;
    int b;
    int t;
    a = (n < 10) ? iouerf_pkg::OFS_RST : iouerf_pkg::OFS_XRST;
    b = rs_n[n];
    t = rs_tot;
    wr(a, 32'h1 << n);
    chk_rd("restart word", a, 32'h1 << n);
    chk("lone edge", rs_tot - t, 0);
    wr(a, 32'h0);
    repeat (3) @(posedge mclk);
    chk("restarted", rs_n[n] - b, 1);
    chk("restart count", rs_tot - t, 1);
  endtask
  function automatic int pick();
    lfsr = lfsr_next(lfsr);
    return int'(lfsr[3:0]);
  endfunction
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    #1;
    chk("powerup restart", unit_out.restart, 32'hffff);
    @(posedge mclk);
    chk_rd("error word", iouerf_pkg::OFS_ERR, err_m);
    chk_rd("status", iouerf_pkg::OFS_STAT, 32'h2);
    chk_rd("restart word", iouerf_pkg::OFS_XRST, 32'h0);
    $display("test reset done");
    u = pick();
    fail_cmd[u] <= 1'b1;
    repeat (3) @(posedge mclk);
    fail_cmd <= 16'h0000;
    repeat (2) @(posedge mclk);
    err_m = 1 << u;
    chk_rd("error word", iouerf_pkg::OFS_ERR, err_m);
    chk_rd("ext error word", iouerf_pkg::OFS_XERR, err_m);
    chk_rd("status", iouerf_pkg::OFS_STAT, 32'h3);
    chk("service", unit_out.service_en, 16'hffff ^ err_m);
    restart_unit(u);
    err_m = 0;
    chk_rd("error word", iouerf_pkg::OFS_ERR, err_m);
    chk("service", unit_out.service_en, 32'hffff);
    $display("test refresh fault done");
    u = pick();
    clash_cmd[u] <= 1'b1;
    repeat (3) @(posedge mclk);
    chk_rd("error word", iouerf_pkg::OFS_ERR, err_m);
    restart_unit(u);
    err_m = 1 << u;
    chk_rd("error word", iouerf_pkg::OFS_ERR, err_m);
    chk_rd("status", iouerf_pkg::OFS_STAT, 32'h1);
    clash_cmd <= 16'h0000;
    restart_unit(u);
    err_m = 0;
    chk_rd("status", iouerf_pkg::OFS_STAT, 32'h2);
    $display("test duplicate done");
    restart_unit(12);
    restart_unit(13);
    chk_rd("ext error word", iouerf_pkg::OFS_XERR, err_m);
    $display("test extended restart done");
    wr(iouerf_pkg::OFS_ICLR, 32'h7);
    u = pick();
    defect_cmd[u] <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("unidentified", unit_out.unidentified, 32'h1 << u);
    chk_rd("status", iouerf_pkg::OFS_STAT, 32'h4);
    chk_rd("irq status", iouerf_pkg::OFS_ISTS, 32'h4);
    chk("irq masked", irq, 1'b0);
    wr(iouerf_pkg::OFS_IEN, 32'h4);
    repeat (2) @(posedge mclk);
    chk("irq", irq, 1'b1);
    chk_rd("irq enable", iouerf_pkg::OFS_IEN, 32'h4);
    defect_cmd <= 16'h0000;
    wr(iouerf_pkg::OFS_ICLR, 32'h4);
    repeat (2) @(posedge mclk);
    chk("irq cleared", irq, 1'b0);
    chk_rd("irq status", iouerf_pkg::OFS_ISTS, 32'h0);
    $display("test defective done");
    wr(8'h20, 32'h1);
    chk("bresp", resp, iouerf_pkg::RESP_SLVERR);
    rd(8'h20);
    chk("rresp", resp, iouerf_pkg::RESP_SLVERR);
    wr(iouerf_pkg::OFS_ERR, 32'hffff);
    chk("bresp ro", resp, iouerf_pkg::RESP_OKAY);
    chk_rd("error word", iouerf_pkg::OFS_ERR, err_m);
    $display("test bus done");
    stop_test();
  end
endmodule
